// ### logic/rom_pkg.sv
package rom_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] DATA_OFS = 8'h04;
  localparam logic [7:0] ADDR_LO_OFS = 8'h08;
  localparam logic [7:0] ADDR_HI_OFS = 8'h0c;
  localparam logic [7:0] GPIO_OFS = 8'h10;
  // ****************************************
  // command register fields
  // ****************************************
  localparam int BUSY_POS = 31;
  localparam int OP_POS = 28;
  localparam int TMO_POS = 9;
  localparam int LOAD_POS = 8;
  localparam int LOC_POS = 0;
  // ****************************************
  // gpio configuration fields
  // ****************************************
  localparam int GP_EN_POS = 0;
  localparam int GP_DAT_POS = 1;
  localparam int GP_CLK_POS = 2;
  localparam int GP_DAT_OE_POS = 3;
  localparam int GP_CLK_OE_POS = 4;
  localparam logic [4:0] GPIO_RST = 5'h01;
  // ****************************************
  // host operations
  // ****************************************
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_LOCK = 3'h1;
  localparam logic [2:0] OP_UNLOCK = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_WRALL = 3'h4;
  localparam logic [2:0] OP_ERASE = 3'h5;
  localparam logic [2:0] OP_ERALL = 3'h6;
  localparam logic [2:0] OP_RELOAD = 3'h7;
  // ****************************************
  // serial frame
  // ****************************************
  localparam logic [7:0] SIGNATURE = 8'ha5;
  localparam logic [2:0] ADDR_BYTES = 3'h6;
  localparam logic [4:0] SHORT_BITS = 5'h0a;
  localparam logic [4:0] LONG_BITS = 5'h12;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYC = (SCLK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam int TIMEOUT_MS = 30;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  // ****************************************
  // controller states
  // ****************************************
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_LOAD = 5'b00010,
    S_CMD = 5'b00100,
    S_GAP = 5'b01000,
    S_POLL = 5'b10000
  } state_t;
endpackage

// ### logic/rom_shifter.sv
`timescale 1ns/1ps
module rom_shifter #(
  parameter int HALF_CYC = rom_pkg::SCLK_HALF_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // frame request
  input wire logic start,
  input wire logic [4:0] nbits,
  input wire logic [4:0] drive_bits,
  input wire logic [17:0] tx_word,
  output logic busy,
  output logic done,
  output logic [7:0] rx_byte,
  // serial side
  input wire logic din,
  output logic sclk,
  output logic dout,
  output logic drive
);
  typedef struct packed {
    logic busy;
    logic done;
    logic sclk;
    logic [15:0] cnt;
    logic [4:0] left;
    logic [4:0] drv;
    logic [17:0] sh;
    logic [7:0] rx;
  } shf_t;

  shf_t q, d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    if (!q.busy) begin
      if (start) begin
        d.busy = 1'b1;
        d.sclk = 1'b0;
        d.cnt = 16'h0000;
        d.left = nbits;
        d.drv = drive_bits;
        d.sh = tx_word;
      end
    end else if (q.cnt == 16'(HALF_CYC - 1)) begin
      d.cnt = 16'h0000;
      if (!q.sclk) begin
        d.sclk = 1'b1;
      end else begin
        // sample after the rising edge so the rom output has settled
        d.sclk = 1'b0;
        d.rx = {q.rx[6:0], din};
        d.sh = {q.sh[16:0], 1'b0};
        d.left = q.left - 5'h01;
        if (q.drv != 5'h00) begin
          d.drv = q.drv - 5'h01;
        end
        if (q.left == 5'h01) begin
          d.busy = 1'b0;
          d.done = 1'b1;
        end
      end
    end else begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy = q.busy;
  assign done = q.done;
  assign rx_byte = q.rx;
  assign sclk = q.sclk;
  assign dout = q.busy & q.sh[17];
  assign drive = q.busy & (q.drv != 5'h00);
endmodule

// ### logic/serial_eeprom_controller.sv
`timescale 1ns/1ps
module serial_eeprom_controller #(
  parameter int TIMEOUT_CYC = rom_pkg::TIMEOUT_CYC,
  parameter int HALF_CYC = rom_pkg::SCLK_HALF_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // station address
  output logic [31:0] station_addr_low,
  output logic [15:0] station_addr_high,
  // rom pins
  output logic rom_cs,
  output logic rom_serial_clock_pin_o,
  output logic rom_serial_clock_pin_oe,
  input wire logic rom_serial_data_pin_i,
  output logic rom_serial_data_pin_o,
  output logic rom_serial_data_pin_oe
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    rom_pkg::state_t st;
    logic launch;
    logic [2:0] idx;
    logic sync1;
    logic sync2;
    logic [31:0] rdata;
    logic busy;
    logic [2:0] op;
    logic [6:0] loc;
    logic tmo;
    logic load_ok;
    logic [7:0] data;
    logic [31:0] addr_lo;
    logic [15:0] addr_hi;
    logic [4:0] gcfg;
    logic [31:0] cnt;
    logic poll_cs;
    logic pin_cs;
    logic pin_ck;
    logic pin_ck_oe;
    logic pin_do;
    logic pin_do_oe;
  } ctl_t;

  ctl_t q, d;
  logic [17:0] tx_word;
  logic [4:0] nbits;
  logic [4:0] drive_bits;
  logic sh_busy;
  logic sh_done;
  logic [7:0] rx_byte;
  logic sh_sclk;
  logic sh_dout;
  logic sh_drive;

  // ****************************************
  // frame builder
  // ****************************************
  // returns {bit count, drive count, left-aligned frame}
  function automatic logic [27:0] build_frame(input logic [2:0] op, input logic [6:0] loc,
                                              input logic [7:0] data);
    logic [17:0] w;
    logic [4:0] n;
    logic [4:0] dr;
    w = 18'h00000;
    n = rom_pkg::SHORT_BITS;
    dr = rom_pkg::SHORT_BITS;
    case (op)
      rom_pkg::OP_READ, rom_pkg::OP_RELOAD: begin
        // data bits belong to the rom, so release the pin after the address
        w = {1'b1, 2'b10, loc, 8'h00};
        n = rom_pkg::LONG_BITS;
      end
      rom_pkg::OP_WRITE: begin
        w = {1'b1, 2'b01, loc, data};
        n = rom_pkg::LONG_BITS;
        dr = rom_pkg::LONG_BITS;
      end
      rom_pkg::OP_WRALL: begin
        w = {1'b1, 2'b00, 2'b01, 5'h00, data};
        n = rom_pkg::LONG_BITS;
        dr = rom_pkg::LONG_BITS;
      end
      rom_pkg::OP_ERASE: begin
        w = {1'b1, 2'b11, loc, 8'h00};
      end
      rom_pkg::OP_ERALL: begin
        w = {1'b1, 2'b00, 2'b10, 5'h00, 8'h00};
      end
      rom_pkg::OP_LOCK: begin
        w = {1'b1, 2'b00, 2'b00, 5'h00, 8'h00};
      end
      rom_pkg::OP_UNLOCK: begin
        w = {1'b1, 2'b00, 2'b11, 5'h00, 8'h00};
      end
      default: begin
        w = 18'h00000;
      end
    endcase
    return {n, dr, w};
  endfunction

  // commands that program the array end with a ready poll
  function automatic logic needs_poll(input logic [2:0] op);
    return (op == rom_pkg::OP_WRITE) || (op == rom_pkg::OP_WRALL) ||
           (op == rom_pkg::OP_ERASE) || (op == rom_pkg::OP_ERALL);
  endfunction

  always_comb begin
    logic [27:0] f;
    f = build_frame((q.st == rom_pkg::S_LOAD) ? rom_pkg::OP_READ : q.op,
                    (q.st == rom_pkg::S_LOAD) ? {4'h0, q.idx} : q.loc, q.data);
    nbits = f[27:23];
    drive_bits = f[22:18];
    tx_word = f[17:0];
  end

  // ****************************************
  // controller
  // ****************************************
  always_comb begin
    d = q;
    d.launch = 1'b0;
    d.sync1 = rom_serial_data_pin_i;
    d.sync2 = q.sync1;

    // register reads answer one cycle later; unmapped reads give zero
    d.rdata = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        rom_pkg::CMD_OFS: begin
          d.rdata[rom_pkg::BUSY_POS] = q.busy;
          d.rdata[rom_pkg::OP_POS +: 3] = q.op;
          d.rdata[rom_pkg::TMO_POS] = q.tmo;
          d.rdata[rom_pkg::LOAD_POS] = q.load_ok;
          d.rdata[rom_pkg::LOC_POS +: 7] = q.loc;
        end
        rom_pkg::DATA_OFS: d.rdata = {24'h000000, q.data};
        rom_pkg::ADDR_LO_OFS: d.rdata = q.addr_lo;
        rom_pkg::ADDR_HI_OFS: d.rdata = {16'h0000, q.addr_hi};
        rom_pkg::GPIO_OFS: d.rdata = {27'h0000000, q.gcfg};
        default: d.rdata = 32'h00000000;
      endcase
    end

    if (reg_wr) begin
      case (reg_addr)
        rom_pkg::CMD_OFS: begin
          // writes during a command are dropped to protect the running frame
          if (!q.busy) begin
            d.op = reg_wdata[rom_pkg::OP_POS +: 3];
            d.loc = reg_wdata[rom_pkg::LOC_POS +: 7];
            if (reg_wdata[rom_pkg::BUSY_POS]) begin
              d.busy = 1'b1;
              d.tmo = 1'b0;
              d.launch = 1'b1;
              d.idx = 3'h0;
              if (reg_wdata[rom_pkg::OP_POS +: 3] == rom_pkg::OP_RELOAD) begin
                d.load_ok = 1'b0;
                d.st = rom_pkg::S_LOAD;
              end else begin
                d.st = rom_pkg::S_CMD;
              end
            end
          end
        end
        rom_pkg::DATA_OFS: d.data = reg_wdata[7:0];
        rom_pkg::ADDR_LO_OFS: d.addr_lo = reg_wdata;
        rom_pkg::ADDR_HI_OFS: d.addr_hi = reg_wdata[15:0];
        rom_pkg::GPIO_OFS: d.gcfg = reg_wdata[4:0];
        default: begin
        end
      endcase
    end

    case (q.st)
      rom_pkg::S_IDLE: begin
        d.poll_cs = 1'b0;
      end
      rom_pkg::S_LOAD: begin
        if (sh_done) begin
          if (q.idx == 3'h0) begin
            if (rx_byte == rom_pkg::SIGNATURE) begin
              d.idx = 3'h1;
              d.launch = 1'b1;
            end else begin
              d.busy = 1'b0;
              d.st = rom_pkg::S_IDLE;
            end
          end else begin
            case (q.idx)
              3'h1: d.addr_lo[7:0] = rx_byte;
              3'h2: d.addr_lo[15:8] = rx_byte;
              3'h3: d.addr_lo[23:16] = rx_byte;
              3'h4: d.addr_lo[31:24] = rx_byte;
              3'h5: d.addr_hi[7:0] = rx_byte;
              default: d.addr_hi[15:8] = rx_byte;
            endcase
            if (q.idx == rom_pkg::ADDR_BYTES) begin
              d.load_ok = 1'b1;
              d.busy = 1'b0;
              d.st = rom_pkg::S_IDLE;
            end else begin
              d.idx = q.idx + 3'h1;
              d.launch = 1'b1;
            end
          end
        end
      end
      rom_pkg::S_CMD: begin
        if (sh_done) begin
          if (q.op == rom_pkg::OP_READ) begin
            d.data = rx_byte;
          end
          if (needs_poll(q.op)) begin
            d.cnt = 32'h00000000;
            d.st = rom_pkg::S_GAP;
          end else begin
            d.busy = 1'b0;
            d.st = rom_pkg::S_IDLE;
          end
        end
      end
      rom_pkg::S_GAP: begin
        // chip select low for half a serial clock before the ready poll
        if (q.cnt == 32'(HALF_CYC - 1)) begin
          d.cnt = 32'h00000000;
          d.poll_cs = 1'b1;
          d.st = rom_pkg::S_POLL;
        end else begin
          d.cnt = q.cnt + 32'h00000001;
        end
      end
      rom_pkg::S_POLL: begin
        // rom holds its output low while programming, high once ready
        if (q.sync2) begin
          d.busy = 1'b0;
          d.poll_cs = 1'b0;
          d.st = rom_pkg::S_IDLE;
        end else if (q.cnt == 32'(TIMEOUT_CYC - 1)) begin
          d.tmo = 1'b1;
          d.busy = 1'b0;
          d.poll_cs = 1'b0;
          d.st = rom_pkg::S_IDLE;
        end else begin
          d.cnt = q.cnt + 32'h00000001;
        end
      end
      default: begin
        d.st = rom_pkg::S_IDLE;
        d.busy = 1'b0;
        d.poll_cs = 1'b0;
      end
    endcase

    // pins leave flops so the rom never sees a glitch on its clock or select
    d.pin_cs = q.gcfg[rom_pkg::GP_EN_POS] & (sh_busy | q.poll_cs);
    d.pin_ck = q.gcfg[rom_pkg::GP_EN_POS] ? sh_sclk : q.gcfg[rom_pkg::GP_CLK_POS];
    d.pin_ck_oe = q.gcfg[rom_pkg::GP_EN_POS] | q.gcfg[rom_pkg::GP_CLK_OE_POS];
    d.pin_do = q.gcfg[rom_pkg::GP_EN_POS] ? sh_dout : q.gcfg[rom_pkg::GP_DAT_POS];
    d.pin_do_oe = q.gcfg[rom_pkg::GP_EN_POS] ? sh_drive : q.gcfg[rom_pkg::GP_DAT_OE_POS];
  end

  // reset starts the automatic station address load
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.st <= rom_pkg::S_LOAD;
      q.launch <= 1'b1;
      q.busy <= 1'b1;
      q.gcfg <= rom_pkg::GPIO_RST;
      q.pin_ck_oe <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // serial engine
  // ****************************************
  rom_shifter #(
    .HALF_CYC(HALF_CYC)
  ) u_shifter (
    .clk(clk),
    .rst(rst),
    .start(q.launch),
    .nbits(nbits),
    .drive_bits(drive_bits),
    .tx_word(tx_word),
    .busy(sh_busy),
    .done(sh_done),
    .rx_byte(rx_byte),
    .din(q.sync2),
    .sclk(sh_sclk),
    .dout(sh_dout),
    .drive(sh_drive)
  );

  // ****************************************
  // pins
  // ****************************************
  assign reg_rdata = q.rdata;
  assign station_addr_low = q.addr_lo;
  assign station_addr_high = q.addr_hi;
  assign rom_cs = q.pin_cs;
  assign rom_serial_clock_pin_o = q.pin_ck;
  assign rom_serial_clock_pin_oe = q.pin_ck_oe;
  assign rom_serial_data_pin_o = q.pin_do;
  assign rom_serial_data_pin_oe = q.pin_do_oe;
endmodule

// ### verif/rom_props.sv
`timescale 1ns/1ps
module rom_props #(
  parameter int TIMEOUT_CYC = 200,
  parameter int HALF_CYC = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [31:0] station_addr_low,
  // rom pins
  input wire logic rom_cs,
  input wire logic rom_serial_clock_pin_o,
  input wire logic rom_serial_clock_pin_oe,
  input wire logic rom_serial_data_pin_o,
  input wire logic rom_serial_data_pin_oe
);
  // longest frame plus the whole ready poll
  localparam int MAX_CS = 36 * HALF_CYC + TIMEOUT_CYC + 8;
  logic [4:0] ck_q;
  logic [4:0] gp_q;
  int hi_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ****************************************
  // helpers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst || !rom_cs) begin
      ck_q <= 5'h00;
      hi_q <= 0;
    end else begin
      hi_q <= hi_q + 1;
      if ($rose(rom_serial_clock_pin_o)) begin
        ck_q <= ck_q + 5'h01;
      end
    end
    if (rst) begin
      gp_q <= rom_pkg::GPIO_RST;
    end else if (reg_wr && reg_addr == rom_pkg::GPIO_OFS) begin
      gp_q <= reg_wdata[4:0];
    end
  end
  // ****************************************
  // properties
  // ****************************************
  property p_start;
    $rose(rom_serial_clock_pin_o) && rom_cs && ck_q == 5'h00 |-> rom_serial_data_pin_o && rom_serial_data_pin_oe;
  endproperty
  a_start: assert property (p_start) else $error("frame does not open with a one");
  property p_count;
    $fell(rom_cs) |-> ck_q == 5'h00 || ck_q == rom_pkg::SHORT_BITS || ck_q == rom_pkg::LONG_BITS;
  endproperty
  a_count: assert property (p_count) else $error("wrong serial clock count");
  property p_high;
    $rose(rom_serial_clock_pin_o) && rom_cs |-> rom_serial_clock_pin_o [*8];
  endproperty
  a_high: assert property (p_high) else $error("serial clock high too short");
  property p_cs_end;
    $fell(rom_cs) |-> !rom_serial_clock_pin_o;
  endproperty
  a_cs_end: assert property (p_cs_end) else $error("clock high at frame end");
  property p_data_edge;
    rom_cs && $past(rom_cs) && rom_serial_data_pin_oe && $changed(rom_serial_data_pin_o)
      |-> $fell(rom_serial_clock_pin_o);
  endproperty
  a_data_edge: assert property (p_data_edge) else $error("data moved off clock fall");
  property p_launch;
    reg_wr && reg_addr == rom_pkg::CMD_OFS && reg_wdata[rom_pkg::BUSY_POS] && !rom_cs |-> ##[1:3] rom_cs;
  endproperty
  a_launch: assert property (p_launch) else $error("command did not start");
  property p_release;
    !gp_q[0] && $stable(gp_q) |-> rom_serial_clock_pin_oe == gp_q[4] && rom_serial_data_pin_oe == gp_q[3]
      && rom_serial_clock_pin_o == gp_q[2] && rom_serial_data_pin_o == gp_q[1];
  endproperty
  a_release: assert property (p_release) else $error("pins not handed to gpio");
  property p_addr_hold;
    $changed(station_addr_low) |-> $past(rom_cs) || $past(rom_cs, 2) || $past(reg_wr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("station address changed idle");
  property p_poll_bound;
    rom_cs |-> hi_q < MAX_CS;
  endproperty
  a_poll_bound: assert property (p_poll_bound) else $error("chip select held too long");
  c_long: cover property ($fell(rom_cs) && ck_q == rom_pkg::LONG_BITS);
  c_short: cover property ($fell(rom_cs) && ck_q == rom_pkg::SHORT_BITS);
  c_gpio: cover property (!gp_q[0] && rom_serial_clock_pin_oe);
endmodule
bind serial_eeprom_controller rom_props #(.TIMEOUT_CYC(TIMEOUT_CYC), .HALF_CYC(HALF_CYC)) u_props (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .station_addr_low(station_addr_low), .rom_cs(rom_cs), .rom_serial_clock_pin_o(rom_serial_clock_pin_o),
  .rom_serial_clock_pin_oe(rom_serial_clock_pin_oe), .rom_serial_data_pin_o(rom_serial_data_pin_o),
  .rom_serial_data_pin_oe(rom_serial_data_pin_oe)
);

// ### verif/rom_model.sv
`timescale 1ns/1ps
module rom_model (
  // serial side
  input wire logic cs,
  input wire logic sclk,
  input wire logic din,
  output logic dout
);
  logic [7:0] mem [0:127];
  logic [17:0] sh;
  logic [8:0] cmd_q;
  logic [7:0] rd_q;
  logic en, pend, rdy, absent;
  int n;
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'(i * 7 + 3);
    mem[0] = 8'ha5;
    en = 1'b0;
    pend = 1'b0;
    rdy = 1'b1;
    absent = 1'b0;
    cmd_q = 9'h000;
    n = 0;
  end
  always @(negedge cs) n = 0;
  // programming takes a while; ready shows only on the poll
  always @(negedge rdy) rdy <= #1000 1'b1;
  always @(posedge sclk) if (cs) begin
    sh = {sh[16:0], din};
    n++;
    pend = 1'b0;
    if (n == 10 && sh[9]) begin
      cmd_q = sh[8:0];
      rd_q = mem[sh[6:0]];
      if (sh[8:5] == 4'b0011) en = 1'b1;
      if (sh[8:5] == 4'b0000) en = 1'b0;
      if (en && sh[8:7] == 2'b11) mem[sh[6:0]] = 8'hff;
      if (en && sh[8:5] == 4'b0010) for (int i = 0; i < 128; i++) mem[i] = 8'hff;
      pend = sh[8:7] == 2'b11 || sh[8:5] == 4'b0010;
    end
    if (n == 18) begin
      if (en && cmd_q[8:7] == 2'b01) mem[cmd_q[6:0]] = sh[7:0];
      if (en && cmd_q[8:5] == 4'b0001) for (int i = 0; i < 128; i++) mem[i] = sh[7:0];
      pend = cmd_q[8:7] == 2'b01 || cmd_q[8:5] == 4'b0001;
    end
    if (pend) rdy = 1'b0;
  end
  // undriven line sits on its pull-down
  assign dout = absent ? 1'b0 : (cs && n == 0 && pend) ? rdy
    : (cmd_q[8:7] == 2'b10 && n > 10 && n < 19) ? rd_q[18 - n] : 1'b0;
endmodule

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk, rst, reg_wr, reg_rd, cs, sck, sck_oe, di, dq, dq_oe, m_dq;
  logic [7:0] reg_addr, b;
  logic [31:0] reg_wdata, reg_rdata, sa_lo, d;
  logic [15:0] sa_hi, s;
  logic [47:0] e;
  logic [6:0] loc;
  int bad_count, checked, ck, last_ck;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  assign di = dq_oe ? dq : m_dq;
  serial_eeprom_controller #(.TIMEOUT_CYC(200)) DUT (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .station_addr_low(sa_lo), .station_addr_high(sa_hi), .rom_cs(cs),
    .rom_serial_clock_pin_o(sck), .rom_serial_clock_pin_oe(sck_oe), .rom_serial_data_pin_i(di),
    .rom_serial_data_pin_o(dq), .rom_serial_data_pin_oe(dq_oe)
  );
  rom_model m (.cs(cs), .sclk(sck), .din(di), .dout(m_dq));
  always @(posedge cs) ck = 0;
  always @(posedge sck) if (cs) ck++;
  always @(negedge cs) if (ck != 0) last_ck = ck;
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic int exp_ck(input logic [2:0] op);
    return (op == rom_pkg::OP_READ || op == rom_pkg::OP_WRITE || op == rom_pkg::OP_WRALL
      || op == rom_pkg::OP_RELOAD) ? 18 : 10;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic wait_idle;
    logic [31:0] v;
    for (int i = 0; i < 3000; i++) begin
      rd(rom_pkg::CMD_OFS, v);
      if (v[rom_pkg::BUSY_POS] === 1'b0) return;
    end
    bad_count++;
    $display("BAD %0t busy never cleared", $time);
  endtask
  // busy is polled through the command register until it clears
  task automatic cmd(input logic [2:0] op, input logic [6:0] l);
    wr(rom_pkg::CMD_OFS, {1'b1, op, 21'h0, l});
    wait_idle;
    chk(32'(last_ck), 32'(exp_ck(op)));
  endtask
  task automatic chk_sa(input logic [47:0] x);
    chk(sa_lo, x[31:0]);
    chk({16'h0, sa_hi}, {16'h0, x[47:32]});
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    #600000;
    bad_count++;
    test_done;
  end
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    bad_count = 0;
    checked = 0;
    last_ck = 0;
    s = 16'h0019;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wait_idle;
    e = {m.mem[6], m.mem[5], m.mem[4], m.mem[3], m.mem[2], m.mem[1]};
    chk_sa(e);
    rd(rom_pkg::CMD_OFS, d);
    chk({31'h0, d[rom_pkg::LOAD_POS]}, 32'h1);
    rd(8'h20, d);
    chk(d, 32'h0);
    cmd(rom_pkg::OP_UNLOCK, 7'h00);
    for (int i = 0; i < 5; i++) begin
      s = lfsr(s);
      loc = (i == 0) ? 7'h7f : s[6:0] | 7'h01;
      wr(rom_pkg::DATA_OFS, {24'h0, s[15:8]});
      cmd(rom_pkg::OP_WRITE, loc);
      chk({24'h0, m.mem[loc]}, {24'h0, s[15:8]});
      wr(rom_pkg::DATA_OFS, 32'h0);
      cmd(rom_pkg::OP_READ, loc);
      rd(rom_pkg::DATA_OFS, d);
      chk(d, {24'h0, s[15:8]});
    end
    b = m.mem[5];
    cmd(rom_pkg::OP_LOCK, 7'h00);
    wr(rom_pkg::DATA_OFS, 32'h3c);
    cmd(rom_pkg::OP_WRITE, 7'h05);
    chk({24'h0, m.mem[5]}, {24'h0, b});
    cmd(rom_pkg::OP_UNLOCK, 7'h00);
    cmd(rom_pkg::OP_ERASE, 7'h05);
    chk({24'h0, m.mem[5]}, 32'hff);
    wr(rom_pkg::DATA_OFS, 32'h5a);
    cmd(rom_pkg::OP_WRALL, 7'h00);
    chk({24'h0, m.mem[7'h33]}, 32'h5a);
    cmd(rom_pkg::OP_ERALL, 7'h00);
    chk({24'h0, m.mem[7'h40]}, 32'hff);
    // failed reload first, so the later success must set the loaded bit itself
    m.mem[0] = 8'h00;
    cmd(rom_pkg::OP_RELOAD, 7'h00);
    chk_sa(e);
    rd(rom_pkg::CMD_OFS, d);
    chk({31'h0, d[rom_pkg::LOAD_POS]}, 32'h0);
    for (int k = 1; k < 7; k++) m.mem[k] = s[7:0] ^ 8'(k * 37);
    m.mem[0] = 8'ha5;
    e = {m.mem[6], m.mem[5], m.mem[4], m.mem[3], m.mem[2], m.mem[1]};
    cmd(rom_pkg::OP_RELOAD, 7'h00);
    chk_sa(e);
    rd(rom_pkg::CMD_OFS, d);
    chk({31'h0, d[rom_pkg::LOAD_POS]}, 32'h1);
    m.absent = 1'b1;
    cmd(rom_pkg::OP_ERASE, 7'h03);
    rd(rom_pkg::CMD_OFS, d);
    chk({31'h0, d[rom_pkg::TMO_POS]}, 32'h1);
    m.absent = 1'b0;
    cmd(rom_pkg::OP_UNLOCK, 7'h00);
    rd(rom_pkg::CMD_OFS, d);
    chk({31'h0, d[rom_pkg::TMO_POS]}, 32'h0);
    wr(rom_pkg::GPIO_OFS, 32'h1e);
    repeat (2) @(posedge clk);
    chk({28'h0, sck_oe, sck, dq_oe, dq}, 32'hf);
    rd(rom_pkg::GPIO_OFS, d);
    chk(d, 32'h1e);
    wr(rom_pkg::GPIO_OFS, 32'h0);
    repeat (2) @(posedge clk);
    chk({28'h0, sck_oe, sck, dq_oe, dq}, 32'h0);
    wr(rom_pkg::GPIO_OFS, 32'h1);
    // a mid-run reset must run the automatic load again
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    e = {m.mem[6], m.mem[5], m.mem[4], m.mem[3], m.mem[2], m.mem[1]};
    wait_idle;
    chk_sa(e);
    test_done;
  end
endmodule
